// ### mcg_top.v
// Function
// - with the selector not at 11 the master clock is the oscillator divided by (in+1)*(out+1).
// - the input prescale field takes 0..3 and the output prescale field 0..14, slowest /60.
// - with both prescale fields at zero in bypass the master clock follows the oscillator level.
// - selector 11 enables the loop and takes the master clock from it.
// - in loop mode master = oscillator * (mul+1) / ((in+1)*(out+1)).
// - in loop mode the vco output passes an output prescaler of out+1.
// - the loop moves the vco rate by one step per window, never in a jump.
// - the vco band field picks 100-150, 150-200 or 200-250 MHz; 11 is reserved.
// - the halve bit makes the cpu clock the master clock or half of it.
// - the system clock always has the cpu clock's rate.
//
// Purpose: master clock generation with bypass prescalers and a digital frequency loop
// Assumes: osc_in is synchronous to aclk and below aclk/2
// Notes:   clocks are produced as levels sampled on aclk; vco rates are scaled to aclk
`timescale 1ns/1ps
`include "mcg_regs.vh"

module mcg_top (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [3:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // oscillator input
    input  wire        osc_in,
    // generated clocks
    output reg         master_clk,
    output reg         cpu_clk,
    output reg         sys_clk,
    output reg         loop_locked
);

    ////////////////////////////////////////////////////////////////////////////
    // control fields

    reg  [1:0]  clock_mechanism_select;
    reg  [1:0]  vco_band_select;
    reg  [1:0]  input_prescale_value;
    reg  [3:0]  output_prescale_value;
    reg  [4:0]  loop_multiplier_value;
    reg         cpu_clock_halve_select;

    // merge a written word into an old one under the byte strobes
    function [31:0] merge;
        input [31:0] old_word;
        input [31:0] new_word;
        input [3:0]  strb;
        integer      i;
        begin
            merge = old_word;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_word[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] ctrl_word;
    assign ctrl_word = {17'h0_0000, loop_multiplier_value, output_prescale_value,
                        input_prescale_value, vco_band_select, clock_mechanism_select};

    wire        pll_mode;
    assign pll_mode = (clock_mechanism_select == `MCG_SEL_PLL);

    reg  [15:0] vco_step;

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: address and data taken in either order

    reg         aw_held;
    reg         w_held;
    reg  [3:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg  [31:0] new_ctrl;
    reg  [31:0] new_sys;

    always @* begin
        new_ctrl = merge(ctrl_word, w_data, w_strb);
        new_sys  = merge({31'h0, cpu_clock_halve_select}, w_data, w_strb);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready          <= 1'b0;
            s_axi_wready           <= 1'b0;
            s_axi_bvalid           <= 1'b0;
            s_axi_bresp            <= `MCG_RESP_OKAY;
            aw_held                <= 1'b0;
            w_held                 <= 1'b0;
            aw_addr                <= 4'h0;
            w_data                 <= 32'h0000_0000;
            w_strb                 <= 4'h0;
            clock_mechanism_select <= `MCG_SEL_RST;
            vco_band_select        <= `MCG_VB_RST;
            input_prescale_value   <= `MCG_IDIV_RST;
            output_prescale_value  <= `MCG_ODIV_RST;
            loop_multiplier_value  <= `MCG_MUL_RST;
            cpu_clock_halve_select <= `MCG_HALVE_RST;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `MCG_RESP_OKAY;
                if (aw_addr == `MCG_ADDR_CLOCK_GENERATION_CONTROL) begin
                    clock_mechanism_select <= new_ctrl[`MCG_SEL_HI:`MCG_SEL_LO];
                    vco_band_select        <= new_ctrl[`MCG_VB_HI:`MCG_VB_LO];
                    input_prescale_value   <= new_ctrl[`MCG_IDIV_HI:`MCG_IDIV_LO];
                    loop_multiplier_value  <= new_ctrl[`MCG_MUL_HI:`MCG_MUL_LO];
                    // 15 is not a legal ratio; it is held at the largest one
                    if (new_ctrl[`MCG_ODIV_HI:`MCG_ODIV_LO] > `MCG_ODIV_MAX) begin
                        output_prescale_value <= `MCG_ODIV_MAX;
                    end else begin
                        output_prescale_value <= new_ctrl[`MCG_ODIV_HI:`MCG_ODIV_LO];
                    end
                end else if (aw_addr == `MCG_ADDR_SYSTEM_CONTROL_ONE) begin
                    cpu_clock_halve_select <= new_sys[0];
                end else if (aw_addr == `MCG_ADDR_STATUS) begin
                    s_axi_bresp <= `MCG_RESP_OKAY;
                end else begin
                    s_axi_bresp <= `MCG_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `MCG_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `MCG_RESP_OKAY;
                if (s_axi_araddr == `MCG_ADDR_CLOCK_GENERATION_CONTROL) begin
                    s_axi_rdata <= ctrl_word;
                end else if (s_axi_araddr == `MCG_ADDR_SYSTEM_CONTROL_ONE) begin
                    s_axi_rdata <= {31'h0, cpu_clock_halve_select};
                end else if (s_axi_araddr == `MCG_ADDR_STATUS) begin
                    s_axi_rdata <= {vco_step, 14'h0000, pll_mode, loop_locked};
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `MCG_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // oscillator edges and input prescaler

    reg         osc_q;
    reg         pll_mode_q;
    wire        osc_edge;
    wire        mode_change;
    wire        in_tick;

    // every edge counts, so a divide by n of edges toggled gives period x n
    assign osc_edge    = osc_in ^ osc_q;
    assign mode_change = pll_mode ^ pll_mode_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_q      <= 1'b0;
            pll_mode_q <= 1'b0;
        end else begin
            osc_q      <= osc_in;
            pll_mode_q <= pll_mode;
        end
    end

    mcg_div u_in_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (mode_change),
        .limit    ({2'b00, input_prescale_value}),
        .tick_in  (osc_edge),
        .tick_out (in_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // digital frequency loop: phase accumulator vco

    reg  [15:0] vco_acc;
    reg  [5:0]  vco_count;
    reg  [15:0] band_lo;
    reg  [15:0] band_hi;
    wire [16:0] acc_sum;
    wire        vco_edge;
    wire [5:0]  target;

    assign acc_sum  = {1'b0, vco_acc} + {1'b0, vco_step};
    assign vco_edge = pll_mode && acc_sum[16];
    assign target   = {1'b0, loop_multiplier_value} + 6'h01;

    always @* begin
        case (vco_band_select)
            2'b01: begin
                band_lo = `MCG_STEP_150;
                band_hi = `MCG_STEP_200;
            end
            2'b10: begin
                band_lo = `MCG_STEP_200;
                band_hi = `MCG_STEP_250;
            end
            default: begin
                // reserved code behaves as the lowest band
                band_lo = `MCG_STEP_100;
                band_hi = `MCG_STEP_150;
            end
        endcase
    end

    // window of in+1 oscillator edges must hold mul+1 vco edges
    always @(posedge aclk) begin
        if (!aresetn) begin
            vco_acc     <= 16'h0000;
            vco_step    <= `MCG_STEP_100;
            vco_count   <= 6'h00;
            loop_locked <= 1'b0;
        end else if (!pll_mode) begin
            vco_acc     <= 16'h0000;
            vco_count   <= 6'h00;
            loop_locked <= 1'b0;
            vco_step    <= band_lo;
        end else begin
            vco_acc <= acc_sum[15:0];
            if (in_tick) begin
                vco_count <= {5'h00, vco_edge};
                // one step per window keeps the rate gliding
                if (vco_count < target && vco_step < band_hi) begin
                    vco_step <= vco_step + 16'h0001;
                end else if (vco_count > target && vco_step > band_lo) begin
                    vco_step <= vco_step - 16'h0001;
                end else if (vco_step < band_lo) begin
                    vco_step <= vco_step + 16'h0001;
                end else if (vco_step > band_hi) begin
                    vco_step <= vco_step - 16'h0001;
                end
                loop_locked <= (vco_count == target);
            end else if (vco_edge && vco_count != 6'h3f) begin
                vco_count <= vco_count + 6'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output prescaler and derived clocks

    wire        src_tick;
    wire        out_tick;

    // bypass feeds input prescaler ticks, loop mode feeds vco edges
    assign src_tick = pll_mode ? vco_edge : in_tick;

    mcg_div u_out_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .clear    (mode_change),
        .limit    (output_prescale_value),
        .tick_in  (src_tick),
        .tick_out (out_tick)
    );

    reg         half_clk;
    reg         next_cpu;

    always @* begin
        // halve toggles on master rising edges only
        if (cpu_clock_halve_select) begin
            next_cpu = (out_tick && !master_clk) ? !half_clk : half_clk;
        end else begin
            next_cpu = out_tick ? !master_clk : master_clk;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            master_clk <= 1'b0;
            half_clk   <= 1'b0;
            cpu_clk    <= 1'b0;
            sys_clk    <= 1'b0;
        end else begin
            // in bypass with both ratios at zero this follows osc_in edge for edge
            if (out_tick) begin
                master_clk <= !master_clk;
            end
            if (out_tick && !master_clk) begin
                half_clk <= !half_clk;
            end
            cpu_clk <= next_cpu;
            sys_clk <= next_cpu;
        end
    end

endmodule // mcg_top

// ### mcg_regs.vh
// Purpose: register map, field positions, reset values and loop limits of the clock generator
// Assumes: AXI4-Lite, 32-bit words, byte addresses
// Notes:   definitions only
`ifndef MCG_REGS_VH
`define MCG_REGS_VH

// register byte offsets
`define MCG_ADDR_CLOCK_GENERATION_CONTROL 4'h0
`define MCG_ADDR_SYSTEM_CONTROL_ONE       4'h4
`define MCG_ADDR_STATUS                   4'h8

// clock_generation_control fields
`define MCG_SEL_LO   0
`define MCG_SEL_HI   1
`define MCG_VB_LO    2
`define MCG_VB_HI    3
`define MCG_IDIV_LO  4
`define MCG_IDIV_HI  5
`define MCG_ODIV_LO  6
`define MCG_ODIV_HI  9
`define MCG_MUL_LO   10
`define MCG_MUL_HI   14

// field values and limits
`define MCG_SEL_PLL      2'b11
`define MCG_ODIV_MAX     4'he
`define MCG_VB_RESERVED  2'b11

// reset values
`define MCG_SEL_RST   2'b00
`define MCG_VB_RST    2'b00
`define MCG_IDIV_RST  2'b00
`define MCG_ODIV_RST  4'h0
`define MCG_MUL_RST   5'h00
`define MCG_HALVE_RST 1'b0

// vco phase step bounds per band, scaled to 100/150/200/250
`define MCG_STEP_100 16'h1000
`define MCG_STEP_150 16'h1800
`define MCG_STEP_200 16'h2000
`define MCG_STEP_250 16'h2800

// axi responses
`define MCG_RESP_OKAY   2'b00
`define MCG_RESP_SLVERR 2'b10

`endif

// ### mcg_div.v
// Purpose: prescaler counting input ticks, one output tick every limit+1 inputs
// Assumes: tick_in is a one-cycle pulse in the aclk domain
// Notes:   clear restarts the count so a mode change starts a fresh ratio
`timescale 1ns/1ps

module mcg_div (
    // clock and reset
    input  wire       aclk,
    input  wire       aresetn,
    // control
    input  wire       clear,
    input  wire [3:0] limit,
    // ticks
    input  wire       tick_in,
    output wire       tick_out
);

    reg  [3:0] count;
    wire       wrap;

    assign wrap     = (count >= limit);
    assign tick_out = tick_in && wrap;

    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            count <= 4'h0;
        end else if (tick_in) begin
            if (wrap) begin
                count <= 4'h0;
            end else begin
                count <= count + 4'h1;
            end
        end
    end

endmodule // mcg_div

// ### mcg_osc_model.sv
// Purpose: oscillator model driving osc_in in step with aclk
// Assumes: half period of at least 2 aclk cycles
// Notes:   free running, as a crystal keeps running
`timescale 1ns/1ps
module mcg_osc_model #(parameter int HALF = 2) (
    // clock
    input  wire  aclk,
    // oscillator level
    output logic osc_in
);
    int cnt = 0;
    initial osc_in = 1'b0;
    always @(posedge aclk) begin
        if (cnt == HALF - 1) begin
            cnt    <= 0;
            osc_in <= ~osc_in;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // mcg_osc_model

// ### mcg_top_sva.sv
// Purpose: port checker for the master clock generator
// Assumes: shadow of the clock generation control word is rebuilt from write traffic
// Notes:   clock checks other than sys against cpu wait until a write has settled for 8 cycles
`timescale 1ns/1ps
`include "mcg_regs.vh"
module mcg_top_sva (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // register bus
    input wire [3:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [3:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // clocks
    input wire        osc_in,
    input wire        master_clk,
    input wire        cpu_clk,
    input wire        sys_clk,
    input wire        loop_locked
);
    logic [3:0]  wa;
    logic [31:0] wd;
    logic [31:0] ctrl;
    logic        m1;
    logic        m2;
    int          age;
    always @(posedge aclk) begin
        if (!aresetn) begin
            wa   <= 4'h0;
            wd   <= 32'h0000_0000;
            ctrl <= 32'h0000_0000;
            m1   <= 1'b0;
            m2   <= 1'b0;
            age  <= 0;
        end else begin
            m1 <= master_clk;
            m2 <= m1;
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata;
            if (s_axi_bvalid && s_axi_bready && wa == `MCG_ADDR_CLOCK_GENERATION_CONTROL)
                ctrl <= wd;
            // a write in flight may already have changed the outputs
            if ((s_axi_awvalid && s_axi_awready) || (s_axi_bvalid && s_axi_bready)) age <= 0;
            else if (age < 1000) age <= age + 1;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_sys_eq_cpu;
        sys_clk == cpu_clk;
    endproperty
    a_sys_eq_cpu: assert property (p_sys_eq_cpu)
        else $error("system clock differs from cpu clock");
    property p_cpu_tracks;
        age > 8 && $changed(cpu_clk) |-> master_clk != m2;
    endproperty
    a_cpu_tracks: assert property (p_cpu_tracks)
        else $error("cpu clock moved without a master clock edge");
    property p_pass_through;
        age > 8 && ctrl[1:0] != `MCG_SEL_PLL && ctrl[9:4] == 6'h00
            |-> master_clk == $past(osc_in, 1);
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("master clock does not follow the oscillator");
    property p_locked_loop;
        $rose(loop_locked) && age > 8 |-> ctrl[1:0] == `MCG_SEL_PLL;
    endproperty
    a_locked_loop: assert property (p_locked_loop)
        else $error("loop locked outside loop mode");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped early");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped early");
    property p_rd_bad;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] == 2'h3
            |=> s_axi_rvalid && s_axi_rresp == `MCG_RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_rd_bad: assert property (p_rd_bad)
        else $error("unmapped read not refused");
    property p_rd_ok;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[3:2] != 2'h3 && s_axi_araddr[1:0] == 2'h0
            |=> s_axi_rvalid && s_axi_rresp == `MCG_RESP_OKAY;
    endproperty
    a_rd_ok: assert property (p_rd_ok)
        else $error("mapped read not answered");
endmodule // mcg_top_sva
bind mcg_top mcg_top_sva i_mcg_top_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .osc_in(osc_in), .master_clk(master_clk), .cpu_clk(cpu_clk), .sys_clk(sys_clk),
    .loop_locked(loop_locked)
);

// ### mcg_top_tb_top.sv
// Purpose: self-checking bench for the master clock generator
// Assumes: oscillator half period 2 aclk, so one oscillator period is 4 aclk
// Notes:   periods are counted in aclk cycles between rising edges
`timescale 1ns/1ps
`include "mcg_regs.vh"
module mcg_top_tb_top;
    logic        aclk          = 1'b0;
    logic        aresetn       = 1'b0;
    logic [3:0]  s_axi_awaddr  = 4'h0;
    logic [3:0]  s_axi_araddr  = 4'h0;
    logic [3:0]  s_axi_wstrb   = 4'h0;
    logic [31:0] s_axi_wdata   = 32'h0000_0000;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid  = 1'b0;
    logic        s_axi_bready  = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready  = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire         osc_in, master_clk, cpu_clk, sys_clk, loop_locked;
    int          fails = 0;
    int          tests_run = 0;
    logic [1:0]  rsp;
    logic [31:0] rd;
    mcg_osc_model i_mcg_osc_model (.aclk(aclk), .osc_in(osc_in));
    mcg_top i_mcg_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .osc_in(osc_in), .master_clk(master_clk),
        .cpu_clk(cpu_clk), .sys_clk(sys_clk), .loop_locked(loop_locked)
    );
    always #20 aclk = ~aclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input bit ok, input string msg);
        tests_run++;
        if (!ok) begin
            fails++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d, checks %0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    function automatic logic [31:0] ctl(input int sel, vb, id, od, mul);
        return {17'h0, mul[4:0], od[3:0], id[1:0], vb[1:0], sel[1:0]};
    endfunction
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        bit aw_done, w_done;
        aw_done = 1'b0;
        w_done  = 1'b0;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_wvalid  <= 1'b1;
        // each channel is released at the edge its own ready is seen
        while (!aw_done || !w_done) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // ready is raised on the edge bvalid rises, so the response is never held
        @(posedge aclk);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_read(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd  = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic per(input int which, output int p);
        int   n, t0, k;
        logic v, prev;
        p    = -1;
        k    = 0;
        t0   = 0;
        prev = 1'b1;
        for (n = 0; n < 1200 && k < 2; n++) begin
            @(posedge aclk);
            v = (which == 0) ? master_clk : (which == 1) ? cpu_clk : sys_clk;
            if (v === 1'b1 && prev === 1'b0) begin
                if (k == 1) p = n - t0;
                t0 = n;
                k++;
            end
            prev = v;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        axi_read(`MCG_ADDR_CLOCK_GENERATION_CONTROL);
        check(rd === 32'h0000_0000 && rsp === `MCG_RESP_OKAY, "control not clear after reset");
        axi_read(4'hc);
        check(rd === 32'h0000_0000 && rsp === `MCG_RESP_SLVERR, "unmapped read accepted");
        axi_write(4'hc, 32'h0000_0003);
        check(rsp === `MCG_RESP_SLVERR, "unmapped write accepted");
    endtask
    task automatic t_bypass();
        int p, i;
        int id[4] = '{0, 1, 0, 3};
        int od[4] = '{0, 0, 2, 14};
        for (i = 0; i < 4; i++) begin
            axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(i % 2, 0, id[i], od[i], 0));
            repeat (20) @(posedge aclk);
            per(0, p);
            check(p == 4 * (id[i] + 1) * (od[i] + 1), "bypass period wrong");
        end
    endtask
    task automatic t_halve();
        int p;
        axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(0, 0, 1, 15, 0));
        axi_read(`MCG_ADDR_CLOCK_GENERATION_CONTROL);
        check(rd === ctl(0, 0, 1, 14, 0), "output prescale not held at 14");
        axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(0, 0, 1, 0, 0));
        axi_write(`MCG_ADDR_SYSTEM_CONTROL_ONE, 32'h0000_0001);
        repeat (20) @(posedge aclk);
        per(1, p);
        check(p == 16, "halved cpu period wrong");
        per(2, p);
        check(p == 16, "system period wrong");
        axi_write(`MCG_ADDR_SYSTEM_CONTROL_ONE, 32'h0000_0000);
        repeat (20) @(posedge aclk);
        per(1, p);
        check(p == 8, "full cpu period wrong");
    endtask
    task automatic t_loop();
        int          b, p;
        logic [15:0] s0, lo, hi;
        for (b = 0; b < 4; b++) begin
            // bypass first so the step restarts at the new band's floor
            axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(0, b, 1, 0, 0));
            axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(3, b, (b % 3 == 0) ? 3 : 1, 0, 0));
            repeat (1500) @(posedge aclk);
            axi_read(`MCG_ADDR_STATUS);
            s0 = rd[31:16];
            lo = (b == 1) ? `MCG_STEP_150 : (b == 2) ? `MCG_STEP_200 : `MCG_STEP_100;
            hi = (b == 1) ? `MCG_STEP_200 : (b == 2) ? `MCG_STEP_250 : `MCG_STEP_150;
            check(rd[1] === 1'b1, "loop mode not entered");
            check(s0 >= lo && s0 <= hi, "vco outside band");
            axi_read(`MCG_ADDR_STATUS);
            check(rd[31:16] <= s0 + 16'h0004 && rd[31:16] + 16'h0004 >= s0, "vco jump");
        end
        // band 10 starts at the step that gives one vco edge per 8 aclk
        axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(0, 2, 1, 0, 0));
        axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(3, 2, 3, 0, 0));
        repeat (1500) @(posedge aclk);
        per(0, p);
        check(p >= 13 && p <= 19, "loop master period wrong");
        axi_read(`MCG_ADDR_STATUS);
        check(rd[0] === 1'b1, "loop not locked");
        axi_write(`MCG_ADDR_CLOCK_GENERATION_CONTROL, ctl(3, 2, 3, 1, 0));
        repeat (100) @(posedge aclk);
        per(0, p);
        check(p >= 27 && p <= 37, "loop output prescale wrong");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_bypass();
        t_halve();
        t_loop();
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge aclk);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule // mcg_top_tb_top
